// ---- src/pdw_pkg.sv ----
// package: register map, field layout, timing and carrier types for the preamble wake block
package pdw_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_EVENT_FLAGS  = 8'h13;
   localparam logic [7:0] ADDR_PATTERN_LOW  = 8'h0d;
   localparam logic [7:0] ADDR_PATTERN_HIGH = 8'h0e;
   localparam logic [7:0] ADDR_POWER_CTRL   = 8'h14;
   localparam logic [7:0] ADDR_PREAMBLE_CFG = 8'h0c;
   localparam logic [7:0] ADDR_DETECT_TIME  = 8'h17;
   localparam logic [7:0] ADDR_WAIT_RATIO   = 8'h18;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int         CTRL_SLAVE_RX_BIT   = 0;
   localparam int         CTRL_WAKE_TIMER_BIT = 1;
   localparam int         CTRL_XO_BIT         = 2;
   localparam int         FLAG_PREAMBLE_BIT   = 0;
   localparam logic [7:0] RST_PATTERN_LOW     = 8'h00;
   localparam logic [7:0] RST_PATTERN_HIGH    = 8'h00;
   localparam logic [7:0] RST_POWER_CTRL      = 8'h00;
   localparam logic [3:0] RST_LENGTH_FIELD    = 4'h0;
   localparam logic [7:0] RST_DETECT_FIELD   = 8'h00;
   localparam logic [6:0] RST_RATIO_FIELD     = 7'h00;

   // ----------------------------------------------------------------
   // timing: detect window = 0.48 ms + field * 0.08 ms
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS    = 4000;
   localparam int DET_BASE_NS      = 480000;
   localparam int DET_STEP_NS      = 80000;
   localparam int DET_BASE_CYCLES  = DET_BASE_NS * 1000 / CLK_PERIOD_PS;
   localparam int DET_STEP_CYCLES  = DET_STEP_NS * 1000 / CLK_PERIOD_PS;
   localparam int OVERSAMPLE       = 16;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PDW_STANDBY = 3'b000,
      PDW_POLL_RX = 3'b001,
      PDW_WAIT    = 3'b010,
      PDW_SLAVE   = 3'b011
   } pdw_state_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pdw_reg_req_s;
endpackage

// ---- src/pdw_fifo.sv ----
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module pdw_fifo import pdw_pkg::*; #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   assign out_valid  = (count != '0);
   assign out_data  = mem[rd_ptr];

   // ready is registered from the next count so a ready output above comes straight from a flop
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         count    <= '0;
         in_ready <= 1'b1;
      end else begin
         if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         count    <= next_count;
         in_ready <= (next_count != (AW+1)'(DEPTH));
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) mem[wr_ptr] <= in_data;
   end
endmodule // pdw_fifo

// ---- src/pdw_matcher.sv ----
// manchester-expanded, phase independent preamble comparator
`timescale 1ns/10ps
module pdw_matcher import pdw_pkg::*; #(
   parameter int RAW_BITS = 16
) (
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic                  clear,
   input  wire logic                  chip_valid,
   input  wire logic                  chip,
   input  wire logic [RAW_BITS-1:0]   pattern,
   input  wire logic [3:0]            length_field,
   output logic                       hit
);
   localparam int CHIPS = 2 * RAW_BITS;
   logic [CHIPS-1:0] history;
   logic [CHIPS-1:0] filled;
   logic [CHIPS-1:0] expected;
   logic [CHIPS-1:0] used;
   logic [CHIPS-1:0] agree;

   // newest chip sits in bit 0; raw bit i owns chips 2i+1 (first) and 2i (second)
   genvar i;
   generate
      for (i = 0; i < RAW_BITS; i++) begin : g_bit
         assign expected[2*i+1] = ~pattern[i];
         assign expected[2*i]   = pattern[i];
         assign used[2*i+1]     = (4'(i) <= length_field);
         assign used[2*i]       = (4'(i) <= length_field);
      end
   endgenerate

   // a sliding compare sees every alignment, so phase does not matter
   assign agree = ~used | (filled & ~(history ^ expected));
   assign hit   = &agree;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         history <= '0;
         filled  <= '0;
      end else if (clear) begin
         history <= '0;
         filled  <= '0;
      end else if (chip_valid) begin
         history <= {history[CHIPS-2:0], chip};
         filled  <= {filled[CHIPS-2:0], 1'b1};
      end
   end
endmodule // pdw_matcher

// ---- src/pdw_top.sv ----
// preamble detector and wake/data output logic of the receiver baseband
// ----------------------------------------------------------------
// Behaviour
// - 4-bit length code: 0 means one raw bit, f means sixteen.
// - 16-bit pattern in two byte registers; bit 0 is the newest bit.
// - demodulated chips shift into history, compared lsb toward msb.
// - raw 0 expands to chips 10, raw 1 to chips 01.
// - code n uses pattern bits n..0, i.e. 2(n+1) chips.
// - hit whenever chip stream matches expanded pattern, any phase.
// - direct receive drives data pin with demodulated data, 16x oversampled.
// - data pin is 1 while in polled receive.
// - no hit in window: go to wait, keep data pin high.
// - hit: data pin falls on entering wait and stays 0.
// - event flag read: pin to 1, clear wake enable, go standby.
// - unread flag after first wait: re-enter polled receive, pin to 1.
// - pending hit drives pin low again at each entry to wait.
// - reading the event flag register clears the hit flag; a hit in the same cycle as the read keeps it set.
// - detect window 0.48 ms to 20.88 ms in 0.08 ms steps.
// - wait interval is 1 to 128 detect windows.
// ----------------------------------------------------------------
`timescale 1ns/10ps
module pdw_top import pdw_pkg::*; #(
   parameter int RAW_BITS    = 16,
   parameter int FIFO_DEPTH  = 8,
   parameter int DET_BASE    = DET_BASE_CYCLES,
   parameter int DET_STEP    = DET_STEP_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       demod_valid,
   input  wire logic       demod_bit,
   output logic            demod_ready,
   output logic            data_out,
   output logic            data_oe
);
   pdw_reg_req_s req;
   assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]  pattern_low;
   logic [7:0]  pattern_high;
   logic [7:0]  power_ctrl;
   logic [3:0]  length_field;
   logic [7:0]  detect_field;
   logic [6:0]  ratio_field;
   logic        hit_flag;
   pdw_state_e  state;
   pdw_state_e  next_state;

   wire wr_low    = req.wr && req.addr == ADDR_PATTERN_LOW;
   wire wr_high   = req.wr && req.addr == ADDR_PATTERN_HIGH;
   wire wr_ctrl   = req.wr && req.addr == ADDR_POWER_CTRL;
   wire wr_cfg    = req.wr && req.addr == ADDR_PREAMBLE_CFG;
   wire wr_det    = req.wr && req.addr == ADDR_DETECT_TIME;
   wire wr_ratio  = req.wr && req.addr == ADDR_WAIT_RATIO;
   wire rd_flags  = req.rd && req.addr == ADDR_EVENT_FLAGS;
   // configuration is frozen while the receiver is active
   wire rx_active = (state == PDW_POLL_RX) || (state == PDW_SLAVE);

   wire [RAW_BITS-1:0] pattern_word = {pattern_high, pattern_low};
   wire                wake_en  = power_ctrl[CTRL_WAKE_TIMER_BIT];
   wire                slave_en = power_ctrl[CTRL_SLAVE_RX_BIT];

   // ----------------------------------------------------------------
   // window timers
   // ----------------------------------------------------------------
   logic [31:0] tick;
   logic [7:0]  win_count;
   wire  [31:0] det_cycles = 32'(DET_BASE) + 32'(DET_STEP) * {24'h0, detect_field};
   wire         win_end    = (tick == det_cycles - 32'd1);
   wire  [7:0]  ratio_wins = {1'b0, ratio_field} + 8'h01;
   wire         det_done   = (state == PDW_POLL_RX) && win_end;
   wire         wait_done  = (state == PDW_WAIT) && win_end && (win_count == ratio_wins - 8'h01);

   // ----------------------------------------------------------------
   // data path: fifo between demodulator and matcher / data pin
   // ----------------------------------------------------------------
   logic       fifo_valid;
   logic       fifo_bit;
   logic [3:0] os_count;
   logic       hit_raw;
   // in direct receive one bit drains per 16 clocks; otherwise drain freely
   wire        fifo_take  = (state == PDW_SLAVE) ? (os_count == 4'(OVERSAMPLE-1)) : 1'b1;
   wire        chip_valid = fifo_valid && fifo_take && (state == PDW_POLL_RX);
   wire        poll_entry = (next_state == PDW_POLL_RX) && (state != PDW_POLL_RX);

   pdw_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (demod_valid),
      .in_ready  (demod_ready),
      .in_data   (demod_bit),
      .out_valid (fifo_valid),
      .out_ready (fifo_take),
      .out_data  (fifo_bit)
   );

   pdw_matcher #(.RAW_BITS(RAW_BITS)) u_match (
      .core_clk     (core_clk),
      .rst          (rst),
      .clear        (poll_entry),
      .chip_valid   (chip_valid),
      .chip         (fifo_bit),
      .pattern      (pattern_word),
      .length_field (length_field),
      .hit          (hit_raw)
   );

   wire hit_event = hit_raw && (state == PDW_POLL_RX);

   // ----------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         PDW_STANDBY: begin
            if (wake_en) next_state = PDW_POLL_RX;
            else if (slave_en) next_state = PDW_SLAVE;
         end
         PDW_POLL_RX: begin
            if (rd_flags) next_state = PDW_STANDBY;
            else if (det_done) next_state = PDW_WAIT;
         end
         PDW_WAIT: begin
            if (rd_flags) next_state = PDW_STANDBY;
            else if (wait_done) next_state = PDW_POLL_RX;
         end
         PDW_SLAVE: begin
            if (!slave_en) next_state = PDW_STANDBY;
         end
         default: next_state = PDW_STANDBY;
      endcase
   end

   // pin is low only in wait with a pending hit; everywhere else high or data
   wire next_data = (next_state == PDW_SLAVE) ? (fifo_valid && fifo_take ? fifo_bit : data_out) :
                    (next_state == PDW_WAIT)  ? ~(hit_flag | hit_event) :
                    1'b1;

   wire next_flag = hit_event | (hit_flag & ~rd_flags);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state    <= PDW_STANDBY;
         hit_flag <= 1'b0;
         data_out <= 1'b1;
         data_oe  <= 1'b1;
      end else begin
         state    <= next_state;
         hit_flag <= next_flag;
         data_out <= next_data;
         data_oe  <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tick      <= '0;
         win_count <= '0;
         os_count  <= '0;
      end else begin
         os_count <= (state == PDW_SLAVE) ? os_count + 4'h1 : 4'h0;
         if (next_state != state || win_end) tick <= '0;
         else tick <= tick + 32'd1;
         if (next_state != state) win_count <= '0;
         else if (win_end) win_count <= win_count + 8'h01;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pattern_low  <= RST_PATTERN_LOW;
         pattern_high <= RST_PATTERN_HIGH;
         power_ctrl   <= RST_POWER_CTRL;
         length_field <= RST_LENGTH_FIELD;
         detect_field <= RST_DETECT_FIELD;
         ratio_field  <= RST_RATIO_FIELD;
      end else begin
         if (wr_low && !rx_active) pattern_low <= req.wdata;
         if (wr_high && !rx_active) pattern_high <= req.wdata;
         if (wr_cfg && !rx_active) length_field <= req.wdata[3:0];
         if (wr_det && !rx_active) detect_field <= req.wdata;
         if (wr_ratio && !rx_active) ratio_field <= req.wdata[6:0];
         if (wr_ctrl) power_ctrl <= req.wdata;
         else if (rd_flags && (state == PDW_POLL_RX || state == PDW_WAIT))
            power_ctrl[CTRL_WAKE_TIMER_BIT] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   logic [7:0] next_rdata;
   always_comb begin
      case (req.addr)
         ADDR_EVENT_FLAGS:  next_rdata = {7'h00, hit_flag};
         ADDR_PATTERN_LOW:  next_rdata = pattern_low;
         ADDR_PATTERN_HIGH: next_rdata = pattern_high;
         ADDR_POWER_CTRL:   next_rdata = power_ctrl;
         ADDR_PREAMBLE_CFG: next_rdata = {4'h0, length_field};
         ADDR_DETECT_TIME:  next_rdata = detect_field;
         ADDR_WAIT_RATIO:   next_rdata = {1'b0, ratio_field};
         default:           next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) reg_rdata <= 8'h00;
      else if (req.rd) reg_rdata <= next_rdata;
   end
endmodule // pdw_top

// ---- testbench/pdw_top_asserts.sv ----
// checker: port-level assertions for the preamble wake block
`timescale 1ns/10ps
module pdw_top_asserts import pdw_pkg::*; (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       demod_valid,
   input wire logic       demod_bit,
   input wire logic       demod_ready,
   input wire logic       data_out,
   input wire logic       data_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic direct_q;
   // mirrors the direct receive enable so pin checks know the pin's role
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         direct_q <= 1'b0;
      else if (reg_wr && reg_addr == ADDR_POWER_CTRL)
         direct_q <= reg_wdata[CTRL_SLAVE_RX_BIT];
   end
   sequence flag_rd_s;
      reg_rd && reg_addr == ADDR_EVENT_FLAGS;
   endsequence
   // a flag read legally releases the wake level, so it must stay absent while low is checked
   sequence no_flag_rd_s;
      (!(reg_rd && reg_addr == ADDR_EVENT_FLAGS))[*8];
   endsequence
   AST_PIN_DRIVEN: assert property (data_oe)
      else $error("data pin not driven");
   AST_RDATA_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data changed without a read");
   AST_FLAG_READ_RELEASE: assert property (flag_rd_s ##0 !direct_q |-> ##2 data_out ##1 data_out)
      else $error("pin not high after flag read");
   AST_READY_RECOVERS: assert property ($fell(demod_ready) |-> ##[1:17] demod_ready)
      else $error("fifo not drained at oversample rate");
   AST_DIRECT_RATE: assert property (direct_q && $changed(data_out) |=> $stable(data_out)[*8])
      else $error("direct data changed faster than oversample rate");
   AST_WAKE_LOW_HOLDS: assert property (!direct_q && $fell(data_out) ##0 no_flag_rd_s |=> !data_out)
      else $error("wake level not held");
   AST_UNMAPPED_ZERO: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_FLAG_CLEARED: assert property (flag_rd_s ##2 flag_rd_s |=> reg_rdata[FLAG_PREAMBLE_BIT] == 1'b0)
      else $error("hit flag not cleared by read");
endmodule // pdw_top_asserts
bind pdw_top pdw_top_asserts i_pdw_top_asserts (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .demod_valid(demod_valid), .demod_bit(demod_bit), .demod_ready(demod_ready),
   .data_out(data_out), .data_oe(data_oe));

// ---- testbench/pdw_mcu_model.sv ----
// partner: microcontroller side counting wake-up edges on the data pin
`timescale 1ns/10ps
module pdw_mcu_model (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic data_out,
   input  wire logic data_oe,
   output int        wake_count
);
   logic last_q;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         last_q     <= 1'b1;
         wake_count <= 0;
      end else begin
         last_q <= data_out;
         if (data_oe && last_q && !data_out)
            wake_count <= wake_count + 1;
      end
   end
endmodule // pdw_mcu_model

// ---- testbench/pdw_top_tb_top.sv ----
// testbench: scenarios for the preamble wake block
`timescale 1ns/10ps
module pdw_top_tb_top import pdw_pkg::*;;
   // ----------------------------------------------------------------
   // harness
   // ----------------------------------------------------------------
   logic       core_clk, rst, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       demod_valid, demod_bit, demod_ready, data_out, data_oe;
   int         wake_count, num_errors, comparisons, n;
   // short windows: detect 20 + 2*5 = 30 cycles, wait one window
   pdw_top #(.DET_BASE(20), .DET_STEP(5)) i_pdw_top (
      .core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .demod_valid(demod_valid), .demod_bit(demod_bit),
      .demod_ready(demod_ready), .data_out(data_out), .data_oe(data_oe));
   pdw_mcu_model i_pdw_mcu_model (.core_clk(core_clk), .rst(rst),
      .data_out(data_out), .data_oe(data_oe), .wake_count(wake_count));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic chk(input string what, input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, dv);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= dv;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, e);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      chk("reg_rdata", reg_rdata, e);
   endtask
   task automatic wait_pin(input logic v, input int m);
      @(negedge core_clk);
      for (int i = 0; i < m && data_out !== v; i++)
         @(negedge core_clk);
      chk("data_out", 8'(data_out), 8'(v));
   endtask
   task automatic stay(input logic v, input int m);
      int bad;
      bad = 0;
      repeat (m) begin
         @(negedge core_clk);
         if (data_out !== v)
            bad++;
      end
      chk("data_out steady", 8'(bad), 8'h00);
   endtask
   // stops early when the fifo refuses, so a fill ends on the first refusal
   task automatic push(input logic b, alt, input int m);
      @(posedge core_clk);
      n = 0;
      demod_bit   <= b;
      demod_valid <= 1'b1;
      for (int i = 0; i < 60; i++) begin
         @(posedge core_clk);
         if (demod_ready)
            n++;
         demod_bit <= b ^ (alt & n[0]);
         if (n == m || !demod_ready)
            break;
      end
      demod_valid <= 1'b0;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      rc(ADDR_PATTERN_LOW, RST_PATTERN_LOW);
      rc(ADDR_POWER_CTRL, RST_POWER_CTRL);
      rc(8'h30, 8'h00);
      chk("data_oe", 8'(data_oe), 8'h01);
      chk("data_out", 8'(data_out), 8'h01);
      $display("test reset done");
   endtask
   task automatic t_regs;
      wr(ADDR_PREAMBLE_CFG, 8'h07);
      wr(ADDR_PATTERN_LOW, 8'hff);
      wr(ADDR_PATTERN_HIGH, 8'ha5);
      wr(ADDR_DETECT_TIME, 8'h02);
      wr(ADDR_WAIT_RATIO, 8'h00);
      rc(ADDR_PREAMBLE_CFG, 8'h07);
      rc(ADDR_PATTERN_HIGH, 8'ha5);
      rc(ADDR_DETECT_TIME, 8'h02);
      rc(ADDR_WAIT_RATIO, 8'h00);
      $display("test registers done");
   endtask
   task automatic t_nohit;
      wr(ADDR_POWER_CTRL, 8'h02);
      wr(ADDR_PATTERN_LOW, 8'h00);
      rc(ADDR_PATTERN_LOW, 8'hff);
      push(1'b0, 1'b0, 50);
      stay(1'b1, 40);
      rc(ADDR_EVENT_FLAGS, 8'h00);
      rc(ADDR_POWER_CTRL, 8'h00);
      chk("wakes", 8'(wake_count), 8'h00);
      $display("test no hit done");
   endtask
   // high pattern byte is junk on purpose: length 7 must ignore it
   task automatic t_hit;
      wr(ADDR_POWER_CTRL, 8'h02);
      push(1'b0, 1'b1, 40);
      wait_pin(1'b0, 80);
      wait_pin(1'b1, 80);
      wait_pin(1'b0, 80);
      rc(ADDR_EVENT_FLAGS, 8'h01);
      rc(ADDR_EVENT_FLAGS, 8'h00);
      chk("data_out", 8'(data_out), 8'h01);
      rc(ADDR_POWER_CTRL, 8'h00);
      chk("wakes", 8'(wake_count), 8'h02);
      $display("test hit done");
   endtask
   task automatic t_direct;
      wr(ADDR_POWER_CTRL, 8'h01);
      push(1'b0, 1'b0, 20);
      chk("fill", 8'(n >= 8 && n <= 9), 8'h01);
      wait_pin(1'b0, 40);
      stay(1'b0, 100);
      push(1'b1, 1'b0, 1);
      wait_pin(1'b1, 200);
      wr(ADDR_POWER_CTRL, 8'h00);
      $display("test direct done");
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      rst         = 1'b1;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      reg_addr    = 8'h00;
      reg_wdata   = 8'h00;
      demod_valid = 1'b0;
      demod_bit   = 1'b0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      t_reset;
      t_regs;
      t_nohit;
      t_hit;
      t_direct;
      test_done;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      num_errors++;
      test_done;
   end
endmodule // pdw_top_tb_top
